// ==== logic/fpe_top.sv ====
// Purpose: byte-selective erase-program sequencer for the on-chip code flash
// Assumes: cpu register port on the system clock; irq, secure and bod enable are synchronous
// Notes: brown-out and hv fault arrive from analog and pass a three-flop filter
`timescale 1ns/1ps
`default_nettype none
module fpe_top #(
  parameter int ERASE_CYC = fpe_pkg::ERASE_CYCLES,
  parameter int PROG_CYC = fpe_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire fpe_pkg::fpe_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic irq_pending,
  input wire logic warm_reset_req,
  input wire logic page_secured,
  input wire logic bod_enabled,
  input wire logic bod_pin,
  input wire logic hv_fault_pin,
  output logic cpu_hold_idle,
  output fpe_pkg::fpe_flash_req_t flash_req,
  output logic [fpe_pkg::PAGE_BYTES-1:0] flash_byte_mask
);
  import fpe_pkg::*;

  localparam logic [TIMER_W-1:0] ERASE_LAST = TIMER_W'(ERASE_CYC - 1);
  localparam logic [TIMER_W-1:0] PROG_LAST = TIMER_W'(PROG_CYC - 1);

  typedef struct packed {
    fpe_state_t st;
    logic [7:0] addr_low;
    logic [7:0] addr_high;
    logic [3:0] status;
    logic [PAGE_BYTES-1:0] flags;
    logic [TIMER_W-1:0] timer;
    logic [IDX_W:0] walk_idx;
    logic rd_pend;
    logic [IDX_W-1:0] rd_idx;
    logic [2:0] bod_s;
    logic [2:0] hv_s;
    logic bod_f;
    logic hv_f;
    logic [7:0] rdata;
    logic fl_wr;
    logic [IDX_W-1:0] fl_idx;
    logic [7:0] fl_data;
  } fpe_core_state_t;

  fpe_core_state_t q, d;
  logic mem_clr;
  logic mem_we;
  logic [IDX_W-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic busy;
  logic abort_irq;

  // ==========================================
  // page buffer
  // 64-byte page buffer
  fpe_page_mem u_page_mem (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .clr(mem_clr),
    .we(mem_we),
    .waddr(q.addr_low[IDX_W-1:0]),
    .wdata(sfr_req.wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  assign busy = (q.st != FPE_IDLE);
  assign abort_irq = irq_pending | warm_reset_req;

  // ==========================================
  // next state
  always_comb begin
    d = q;
    mem_clr = 1'b0;
    mem_we = 1'b0;
    mem_raddr = q.walk_idx[IDX_W-1:0];
    d.fl_wr = 1'b0;
    d.rd_pend = 1'b0;

    // three-flop filters on analog inputs
    d.bod_s = {q.bod_s[1:0], bod_pin};
    d.hv_s = {q.hv_s[1:0], hv_fault_pin};
    if (q.bod_s[2] == q.bod_s[1]) begin
      d.bod_f = q.bod_s[2];
    end
    if (q.hv_s[2] == q.hv_s[1]) begin
      d.hv_f = q.hv_s[2];
    end

    // read side of the register port
    // status on read
    case (sfr_req.addr)
      ADDR_CMD_STATUS: d.rdata = {4'h0, q.status};
      ADDR_ADDR_LOW: d.rdata = q.addr_low;
      ADDR_ADDR_HIGH: d.rdata = q.addr_high;
      default: d.rdata = 8'h00;
    endcase

    // write side, only while no cycle runs
    if (sfr_req.wr && !busy) begin
      case (sfr_req.addr)
        ADDR_CMD_STATUS: begin
          d.status = STATUS_RESET;
          if (sfr_req.wdata == CMD_LOAD) begin
            mem_clr = 1'b1;
            d.flags = '0;
          end else if (sfr_req.wdata == CMD_ERASE_PROG) begin
            if (page_secured) begin
              d.status[SECURITY_VIOLATION_BIT] = 1'b1;
            end else if (!bod_enabled) begin
              d.status[HV_ABORT_BIT] = 1'b1;
            end else begin
              d.st = FPE_ERASE;
              d.timer = '0;
            end
          end
        end
        ADDR_ADDR_LOW: d.addr_low = sfr_req.wdata;
        ADDR_ADDR_HIGH: d.addr_high = sfr_req.wdata;
        ADDR_DATA_IN: begin
          mem_we = 1'b1;
          d.flags[q.addr_low[IDX_W-1:0]] = 1'b1;
          d.addr_low = {q.addr_low[7:6], q.addr_low[5:0] + 6'h01};
        end
        default: begin
        end
      endcase
    end

    // sequencer
    case (q.st)
      FPE_IDLE: begin
      end
      FPE_ERASE: begin
        d.timer = q.timer + TIMER_W'(1);
        if (q.timer == ERASE_LAST) begin
          d.st = FPE_PROG;
          d.timer = '0;
          d.walk_idx = '0;
        end
      end
      FPE_PROG: begin
        d.timer = q.timer + TIMER_W'(1);
        if (!q.walk_idx[IDX_W]) begin
          d.rd_pend = 1'b1;
          d.rd_idx = q.walk_idx[IDX_W-1:0];
          d.walk_idx = q.walk_idx + (IDX_W+1)'(1);
        end
        if (q.rd_pend && q.flags[q.rd_idx]) begin
          d.fl_wr = 1'b1;
          d.fl_idx = q.rd_idx;
          d.fl_data = mem_rdata;
        end
        if (q.timer == PROG_LAST) begin
          d.st = FPE_IDLE;
        end
      end
      default: d.st = FPE_IDLE;
    endcase

    // aborts, result left in status
    if (busy) begin
      if (q.hv_f) begin
        d.status[HV_ERROR_BIT] = 1'b1;
        d.st = FPE_IDLE;
      end
      if (abort_irq) begin
        d.status[OP_INTERRUPTED_BIT] = 1'b1;
        d.status[HV_ABORT_BIT] = 1'b1;
        d.st = FPE_IDLE;
      end
      if (q.bod_f) begin
        d.status[HV_ABORT_BIT] = 1'b1;
        d.st = FPE_IDLE;
      end
      if (d.st == FPE_IDLE) begin
        d.fl_wr = 1'b0;
        d.rd_pend = 1'b0;
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= FPE_IDLE;
      q.addr_low <= ADDR_LOW_RESET;
      q.addr_high <= ADDR_HIGH_RESET;
      q.status <= STATUS_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================
  // outputs
  // cpu held while busy
  assign cpu_hold_idle = busy;
  assign sfr_rdata = q.rdata;
  assign flash_req.page = {q.addr_high, q.addr_low[7:6]};
  assign flash_req.erase = (q.st == FPE_ERASE);
  assign flash_req.prog = (q.st == FPE_PROG);
  assign flash_req.wr = q.fl_wr;
  assign flash_req.byte_idx = q.fl_idx;
  assign flash_req.data = q.fl_data;
  assign flash_byte_mask = q.flags;
endmodule
`default_nettype wire

// ==== common/fpe_pkg.sv ====
// Purpose: shared constants and carrier types of the flash page erase-program sequencer
// Assumes: 200 MHz system clock, special-function register access by the cpu core
// Notes: register offsets other than the command/status register are local picks
// Operation
// - command/status reads give flags; writes are commands, never stored for readback
// - any command write clears all status flags
// - page buffer of 64 bytes, one update flag per byte
// - load command 00h clears every buffer byte and update flag
// - data write stores at address-low[5:0] and sets that update flag
// - address-low[5:0] increments after data write, wraps, bits 7:6 untouched
// - page select is address-high concatenated with address-low[7:6]
// - only flagged bytes of the selected page are erased and rewritten
// - command 68h starts cycle; cpu held idle until done or interrupted
// - when idle ends, status holds the result of that cycle
// - interrupt or reset abort sets operation-interrupted flag, bit 0
// - cycle lasts 4 ms: 2 ms erase then 2 ms program
// - secured page target sets security-violation flag, bit 1
// - high voltage generator fault sets high-voltage-error flag, bit 2
// - interrupt, brown-out, or brown-out detector disabled sets high-voltage-abort, bit 3
package fpe_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] ADDR_CMD_STATUS = 8'he4;
  localparam logic [7:0] ADDR_DATA_IN = 8'he5;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'he6;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'he7;
  // ==========================================
  // commands, fields, reset values
  localparam logic [7:0] CMD_LOAD = 8'h00;
  localparam logic [7:0] CMD_ERASE_PROG = 8'h68;
  localparam int OP_INTERRUPTED_BIT = 0;
  localparam int SECURITY_VIOLATION_BIT = 1;
  localparam int HV_ERROR_BIT = 2;
  localparam int HV_ABORT_BIT = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
  localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
  localparam int PAGE_BYTES = 64;
  localparam int IDX_W = 6;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint ERASE_TIME_NS = 2000000;
  localparam longint PROG_TIME_NS = 2000000;
  localparam int ERASE_CYCLES = int'((ERASE_TIME_NS * 1000) / CLK_PERIOD_PS);
  localparam int PROG_CYCLES = int'((PROG_TIME_NS * 1000) / CLK_PERIOD_PS);
  localparam int TIMER_W = 20;
  // ==========================================
  // types
  typedef enum logic [2:0] {
    FPE_IDLE = 3'b001,
    FPE_ERASE = 3'b010,
    FPE_PROG = 3'b100
  } fpe_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpe_sfr_req_t;

  typedef struct packed {
    logic erase;
    logic prog;
    logic wr;
    logic [9:0] page;
    logic [5:0] byte_idx;
    logic [7:0] data;
  } fpe_flash_req_t;
endpackage

// ==== logic/fpe_page_mem.sv ====
// Purpose: 64-byte page buffer with whole-buffer clear and registered read data
// Assumes: single write port, single read port, same clock
// Notes: clear wins over a write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module fpe_page_mem (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic we,
  input wire logic [fpe_pkg::IDX_W-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [fpe_pkg::IDX_W-1:0] raddr,
  output logic [7:0] rdata
);
  import fpe_pkg::*;

  typedef struct packed {
    logic [PAGE_BYTES-1:0][7:0] mem;
    logic [7:0] rdata;
  } fpe_mem_state_t;

  fpe_mem_state_t q, d;
  logic [PAGE_BYTES-1:0][7:0] next_w;

  // ==========================================
  // per-entry next value
  genvar i;
  generate
    for (i = 0; i < PAGE_BYTES; i++) begin : g_entry
      assign next_w[i] = clr ? 8'h00 :
                         (we && waddr == IDX_W'(i)) ? wdata : q.mem[i];
    end
  endgenerate

  always_comb begin
    d = q;
    d.mem = next_w;
    d.rdata = q.mem[raddr];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
endmodule
`default_nettype wire

// ==== tb/fpe_top_sva.sv ====
// Purpose: port-level checks of the erase-program sequencer
// Assumes: bound onto fpe_top, single clock domain
// Notes: phase lengths counted by helper counters
`timescale 1ns/1ps
`default_nettype none
module fpe_top_sva #(
  parameter int ERASE_CYC = 80,
  parameter int PROG_CYC = 80
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire fpe_pkg::fpe_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic irq_pending,
  input wire logic warm_reset_req,
  input wire logic page_secured,
  input wire logic bod_enabled,
  input wire logic bod_pin,
  input wire logic hv_fault_pin,
  input wire logic cpu_hold_idle,
  input wire fpe_pkg::fpe_flash_req_t flash_req,
  input wire logic [fpe_pkg::PAGE_BYTES-1:0] flash_byte_mask
);
  import fpe_pkg::*;
  // ==========================================
  // helper logic
  logic cmd;
  logic go;
  logic [19:0] ecnt_q;
  logic [19:0] pcnt_q;
  assign cmd = ce && sfr_req.wr && sfr_req.addr == ADDR_CMD_STATUS && !cpu_hold_idle;
  assign go = cmd && sfr_req.wdata == CMD_ERASE_PROG && !irq_pending && !warm_reset_req;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ecnt_q <= '0;
      pcnt_q <= '0;
    end else if (ce) begin
      ecnt_q <= flash_req.erase ? ecnt_q + 20'h1 : '0;
      pcnt_q <= flash_req.prog ? pcnt_q + 20'h1 : '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // assertions
  start_cyc_a: assert property (go && !page_secured && bod_enabled |=> cpu_hold_idle && flash_req.erase)
    else $error("cycle did not start");
  secure_block_a: assert property (go && page_secured |=> !cpu_hold_idle [*2])
    else $error("secured page started a cycle");
  bod_off_a: assert property (go && !bod_enabled |=> !cpu_hold_idle)
    else $error("cycle started with brown-out detector off");
  irq_abort_a: assert property (ce && cpu_hold_idle && irq_pending |=> !cpu_hold_idle)
    else $error("interrupt did not abort");
  load_clear_a: assert property (cmd && sfr_req.wdata == CMD_LOAD |=> flash_byte_mask == '0)
    else $error("load left flags set");
  erase_len_a: assert property ($fell(flash_req.erase) && flash_req.prog |-> ecnt_q == ERASE_CYC)
    else $error("erase phase length wrong");
  phase_cap_a: assert property (ecnt_q <= ERASE_CYC && pcnt_q <= PROG_CYC)
    else $error("phase overran");
  wr_flag_a: assert property (flash_req.wr |-> flash_req.prog && flash_byte_mask[flash_req.byte_idx])
    else $error("write to unflagged byte");
  page_sel_a: assert property (ce && sfr_req.wr && sfr_req.addr == ADDR_ADDR_HIGH && !cpu_hold_idle
    |=> flash_req.page[9:2] == $past(sfr_req.wdata))
    else $error("page select not from address high");
  status_clr_a: assert property (cmd && sfr_req.wdata != CMD_ERASE_PROG ##1 sfr_req.addr == ADDR_CMD_STATUS
    |=> sfr_rdata == 8'h00)
    else $error("command did not clear status");
  cover property (go);
  cover property (cpu_hold_idle && irq_pending);
  cover property (flash_req.wr);
endmodule
bind fpe_top fpe_top_sva #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) fpe_top_sva_i (.clk(clk), .resetn(resetn),
  .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .irq_pending(irq_pending), .warm_reset_req(warm_reset_req),
  .page_secured(page_secured), .bod_enabled(bod_enabled), .bod_pin(bod_pin), .hv_fault_pin(hv_fault_pin),
  .cpu_hold_idle(cpu_hold_idle), .flash_req(flash_req), .flash_byte_mask(flash_byte_mask));
`default_nettype wire

// ==== tb/fpe_flash_model.sv ====
// Purpose: behavioural code flash array behind the sequencer
// Assumes: one byte per write pulse
// Notes: bytes never written are absent from the map
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model (
  input wire logic clk,
  input wire fpe_pkg::fpe_flash_req_t flash_req
);
  import fpe_pkg::*;
  // ==========================================
  // array
  logic [7:0] mem [int];
  int n_wr = 0;
  always @(posedge clk) begin
    if (flash_req.wr === 1'b1) begin
      mem[{flash_req.page, flash_req.byte_idx}] = flash_req.data;
      n_wr++;
    end
  end
endmodule
`default_nettype wire

// ==== tb/flash_page_erase_program_tb.sv ====
// Purpose: self-checking bench of the erase-program sequencer
// Assumes: phases shortened to 80 cycles each
// Notes: status reads take two cycles
`timescale 1ns/1ps
`default_nettype none
module flash_page_erase_program_tb;
  import fpe_pkg::*;
  // ==========================================
  // stimulus and instances
  localparam int EC = 80;
  localparam int PC = 80;
  logic clk = 0;
  logic resetn = 0;
  logic ce = 1;
  logic irq_pending = 0, warm_reset_req = 0, page_secured = 0, bod_enabled = 1, bod_pin = 0, hv_fault_pin = 0;
  fpe_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic busy;
  fpe_flash_req_t freq;
  logic [63:0] mask;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  always #2.5 clk = ~clk;
  fpe_top #(.ERASE_CYC(EC), .PROG_CYC(PC)) fpe_top_i (.clk(clk), .resetn(resetn), .ce(ce), .sfr_req(req),
    .sfr_rdata(rdata), .irq_pending(irq_pending), .warm_reset_req(warm_reset_req), .page_secured(page_secured),
    .bod_enabled(bod_enabled), .bod_pin(bod_pin), .hv_fault_pin(hv_fault_pin), .cpu_hold_idle(busy),
    .flash_req(freq), .flash_byte_mask(mask));
  fpe_flash_model fpe_flash_model_i (.clk(clk), .flash_req(freq));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    req.addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(rdata, exp, what);
  endtask
  task automatic run();
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    rd(ADDR_CMD_STATUS, 8'h00, "status reset");
    rd(ADDR_ADDR_LOW, 8'h00, "addr low reset");
    rd(ADDR_ADDR_HIGH, 8'h00, "addr high reset");
    rd(8'h10, 8'h00, "unmapped");
    wr(ADDR_CMD_STATUS, 8'h0f);
    rd(ADDR_CMD_STATUS, 8'h00, "command not stored");
    @(posedge clk) ce <= 1'b0;
    wr(ADDR_ADDR_HIGH, 8'h5a);
    @(posedge clk) ce <= 1'b1;
    rd(ADDR_ADDR_HIGH, 8'h00, "frozen by clock enable");
    $display("done regs");
  endtask
  task automatic t_refuse();
    @(posedge clk) page_secured <= 1'b1;
    wr(ADDR_CMD_STATUS, CMD_ERASE_PROG);
    rd(ADDR_CMD_STATUS, 8'h02, "secured");
    @(posedge clk) page_secured <= 1'b0;
    wr(ADDR_CMD_STATUS, 8'h55);
    rd(ADDR_CMD_STATUS, 8'h00, "cleared");
    @(posedge clk) bod_enabled <= 1'b0;
    wr(ADDR_CMD_STATUS, CMD_ERASE_PROG);
    rd(ADDR_CMD_STATUS, 8'h08, "bod off");
    @(posedge clk) bod_enabled <= 1'b1;
    $display("done refuse");
  endtask
  task automatic t_prog();
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    wr(ADDR_ADDR_HIGH, 8'h12);
    wr(ADDR_ADDR_LOW, 8'h7e);
    wr(ADDR_DATA_IN, 8'ha1);
    wr(ADDR_DATA_IN, 8'hb2);
    wr(ADDR_DATA_IN, 8'hc3);
    rd(ADDR_ADDR_LOW, 8'h41, "wrap");
    wr(ADDR_CMD_STATUS, 8'h55);
    chk(mask, 64'hc000_0000_0000_0001, "flags");
    chk(freq.page, 10'h049, "page");
    wr(ADDR_CMD_STATUS, CMD_ERASE_PROG);
    run();
    chk(n, EC + PC, "cycle length");
    chk(fpe_flash_model_i.n_wr, 3, "write count");
    chk(fpe_flash_model_i.mem[16'h127e], 8'ha1, "byte 3e");
    chk(fpe_flash_model_i.mem[16'h127f], 8'hb2, "byte 3f");
    chk(fpe_flash_model_i.mem[16'h1240], 8'hc3, "byte 00");
    rd(ADDR_CMD_STATUS, 8'h00, "status after");
    $display("done prog");
  endtask
  task automatic t_abort(input int k, input logic [7:0] exp);
    wr(ADDR_CMD_STATUS, CMD_ERASE_PROG);
    repeat (10) @(posedge clk);
    {irq_pending, warm_reset_req, bod_pin, hv_fault_pin} <= 4'b1000 >> k;
    repeat (6) @(posedge clk);
    {irq_pending, warm_reset_req, bod_pin, hv_fault_pin} <= 4'h0;
    run();
    rd(ADDR_CMD_STATUS, exp, "abort status");
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    rd(ADDR_CMD_STATUS, 8'h00, "reload");
    $display("done abort %0d", k);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_refuse();
    t_prog();
    t_abort(0, 8'h09);
    t_abort(1, 8'h09);
    t_abort(2, 8'h08);
    t_abort(3, 8'h04);
    wrap_up();
  end
  initial begin
    #50000;
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
